// file: design/low_energy_down_timer_repeat.sv
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
// Low-energy 16-bit down timer with compare flags, top value and repeat modes.
module low_energy_down_timer_repeat #(
   parameter int CNT_WIDTH = down_timer_pkg::CNT_W,
   parameter int REP_WIDTH = down_timer_pkg::REP_W
) (
   input  wire logic                     clk,          // System clock, 100 MHz.
   input  wire logic                     reset_n,      // Asynchronous reset, active low.
   input  wire logic                     clkEn,        // Freezes all state but the reset synchronizer while low.
   input  wire logic                     lfTick,       // Low-frequency clock tick, one cycle.
   input  wire logic                     rtcMatch0,    // Trigger channel zero match pulse.
   input  wire logic                     rtcMatch1,    // Trigger channel one match pulse.
   input  wire down_timer_pkg::bus_req_t busReq,       // Register access request.
   output logic [31:0]                   rdata,        // Read data, cycle after read.
   output logic                          running,      // Timer is counting.
   output logic [down_timer_pkg::FL_W-1:0] flags       // Sticky event flags.
);
   import down_timer_pkg::*;

   logic                 rstMeta_r, rstSync_r;
   ctrl_t                ctrl_r;
   logic [PRESC_W-1:0]   presc_r;
   logic [14:0]          divCnt_r;
   logic                 tick;
   logic [CNT_WIDTH-1:0] cnt_r, first_compare_value_r, second_compare_value_r;
   logic [REP_WIDTH-1:0] first_repeat_count_r, second_repeat_count_r;
   logic                 second_repeat_consumed_r;
   logic                 clrPend_r, clrWrap;
   logic [FL_W-1:0]      setFl;
   logic                 wrCtrl, wrCmd, wrComp0, wrComp1, wrRep0, wrRep1, wrClr;
   logic                 cmdStart, cmdStop, cmdClear, trig, startEv;
   logic                 uf, decRep0, decRep1, bufLoad, startLoad, stopNow;
   logic [CNT_WIDTH-1:0] topVal;
   repeat_mode_t         mode;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
      hit = busReq.wr && (a == ofs);
   endfunction

   // Reset is released through two flops so the rest sees a clean edge.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta_r <= 1'b0;
         rstSync_r <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_r <= rstMeta_r;
      end
   end

   assign wrCtrl  = hit(busReq.addr, OFS_CTRL);
   assign wrCmd   = hit(busReq.addr, OFS_CMD);
   assign wrComp0 = hit(busReq.addr, OFS_FIRST_COMPARE_VALUE);
   assign wrComp1 = hit(busReq.addr, OFS_SECOND_COMPARE_VALUE);
   assign wrRep0  = hit(busReq.addr, OFS_FIRST_REPEAT_COUNT);
   assign wrRep1  = hit(busReq.addr, OFS_SECOND_REPEAT_COUNT);
   assign wrClr   = hit(busReq.addr, OFS_FLCLR);
   assign cmdStart = wrCmd && busReq.wdata[CMD_START];
   assign cmdStop  = wrCmd && busReq.wdata[CMD_STOP];
   assign cmdClear = wrCmd && busReq.wdata[CMD_CLEAR];
   assign mode = repeat_mode_t'(ctrl_r.repeatModeSelect);

   // Control and prescaler registers.
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         ctrl_r  <= '0;
         presc_r <= PRESC_RESET;
      end else if (clkEn) begin
         if (wrCtrl) ctrl_r <= busReq.wdata[5:0];
         if (hit(busReq.addr, OFS_PRESC)) presc_r <= busReq.wdata[PRESC_W-1:0];
      end
   end

   // prescaled timer tick
   // Divides the low-frequency tick by two to the exponent; exponent zero passes it through.
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         divCnt_r <= '0;
      end else if (clkEn && lfTick) begin
         divCnt_r <= divCnt_r + 15'h0001;
      end
   end
   assign tick = lfTick && ((divCnt_r & ((15'h0001 << presc_r) - 15'h0001)) == 15'h0000);

   // one per tick
   // Triggers are sampled only on a timer tick, so a slow tick misses short events.
   assign trig    = tick && ((ctrl_r.rtcChannelZeroTriggerEnable && rtcMatch0) ||
                             (ctrl_r.rtcChannelOneTriggerEnable && rtcMatch1));
   assign startEv = cmdStart || trig;

   // silent wrap after clear
   // A wrap from zero on the first running tick after a clear is not an underflow: no underflow flag, no repeat step.
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         clrPend_r <= 1'b0;
      end else if (clkEn) begin
         if (cmdClear) clrPend_r <= 1'b1;
         else if (running && tick) clrPend_r <= 1'b0;
      end
   end
   assign clrWrap = running && tick && (cnt_r == '0) && clrPend_r && !cmdClear;

   // underflow event
   // A clear in the same cycle wins, so the repeat counters are left untouched.
   assign uf      = running && tick && (cnt_r == '0) && !clrPend_r && !cmdClear;
   assign topVal  = ctrl_r.compareAsTopEnable ? first_compare_value_r : CNT_WRAP;
   // A buffered reload happens when the first repeat is about to hit zero.
   assign bufLoad = uf && (mode == MODE_BUFFERED) && (first_repeat_count_r == 8'h01) &&
                    !second_repeat_consumed_r && (second_repeat_count_r != '0);
   assign startLoad = startEv && !running && (mode == MODE_BUFFERED) && (cnt_r == '0) &&
                      (first_repeat_count_r == '0) && (second_repeat_count_r != '0);
   assign decRep0 = uf && (mode != MODE_FREE) && (first_repeat_count_r != '0);
   assign decRep1 = uf && (mode == MODE_DOUBLE) && (second_repeat_count_r != '0);

   // Stop condition for each repeat mode after this underflow.
   always_comb begin
      case (mode)
         MODE_FREE:     stopNow = 1'b0;
         MODE_ONESHOT:  stopNow = decRep0 && (first_repeat_count_r == 8'h01) && !wrRep0;
         MODE_BUFFERED: stopNow = decRep0 && (first_repeat_count_r == 8'h01) && !wrRep0 && !bufLoad;
         MODE_DOUBLE:   stopNow = uf && !wrRep0 && !wrRep1 &&
                                  (first_repeat_count_r <= 8'h01) && (second_repeat_count_r <= 8'h01);
         default:       stopNow = 1'b0;
      endcase
   end

   // stop wins
   // Run state: stop beats start; a non-free mode needs a nonzero repeat to start.
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         running <= 1'b0;
      end else if (clkEn) begin
         if (cmdStop) running <= 1'b0;
         else if (startEv && !running) running <= (mode == MODE_FREE) || startLoad ||
                                                  (first_repeat_count_r != '0) ||
                                                  ((mode == MODE_DOUBLE) && (second_repeat_count_r != '0));
         else if (stopNow) running <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         cnt_r <= CNT_RESET;
      end else if (clkEn) begin
         if (cmdClear) cnt_r <= CNT_RESET;
         // start load counter from top buffer
         else if (startLoad && ctrl_r.bufferedTopEnable) cnt_r <= second_compare_value_r;
         else if (uf || clrWrap) cnt_r <= bufLoad && ctrl_r.bufferedTopEnable ? second_compare_value_r : topVal;
         else if (running && tick) cnt_r <= cnt_r - 16'h0001;
      end
   end

   // Compare registers with the buffered top copy.
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         first_compare_value_r <= CNT_RESET;
         second_compare_value_r <= CNT_RESET;
      end else if (clkEn) begin
         if (wrComp1) second_compare_value_r <= busReq.wdata[CNT_WIDTH-1:0];
         if (wrComp0) first_compare_value_r <= busReq.wdata[CNT_WIDTH-1:0];
         else if (ctrl_r.bufferedTopEnable && (decRep0 && first_repeat_count_r == 8'h01 || startLoad))
            first_compare_value_r <= second_compare_value_r;
      end
   end

   // Repeat counters and the consumed marker.
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         first_repeat_count_r     <= REP_RESET;
         second_repeat_count_r     <= REP_RESET;
         second_repeat_consumed_r <= 1'b0;
      end else if (clkEn) begin
         if (wrRep0) first_repeat_count_r <= busReq.wdata[REP_WIDTH-1:0];
         else if (bufLoad || startLoad) first_repeat_count_r <= second_repeat_count_r;
         else if (decRep0) first_repeat_count_r <= first_repeat_count_r - 8'h01;
         if (wrRep1) second_repeat_count_r <= busReq.wdata[REP_WIDTH-1:0];
         else if (decRep1) second_repeat_count_r <= second_repeat_count_r - 8'h01;
         if (wrRep1) second_repeat_consumed_r <= 1'b0;
         else if (bufLoad || startLoad) second_repeat_consumed_r <= 1'b1;
      end
   end

   // Event sources for the sticky flags; a clear command never raises underflow.
   always_comb begin
      setFl = '0;
      setFl[FL_FIRST_COMPARE_VALUE] = running && tick && (cnt_r == first_compare_value_r);
      setFl[FL_SECOND_COMPARE_VALUE] = running && tick && (cnt_r == second_compare_value_r);
      setFl[FL_UF]    = uf && !cmdClear;
      setFl[FL_FIRST_REPEAT_COUNT]  = (decRep0 && first_repeat_count_r == 8'h01 && !wrRep0) || bufLoad || startLoad;
      setFl[FL_SECOND_REPEAT_COUNT]  = decRep1 && second_repeat_count_r == 8'h01 && !wrRep1;
   end

   // sticky flags
   // A set arriving with its clear wins, so no event is lost.
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         flags <= '0;
      end else if (clkEn) begin
         flags <= (flags & ~(wrClr ? busReq.wdata[FL_W-1:0] : '0)) | setFl;
      end
   end

   // Read data stands in the cycle after the read strobe only.
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         rdata <= '0;
      end else if (clkEn) begin
         rdata <= '0;
         if (busReq.rd) begin
            case (busReq.addr)
               OFS_CTRL:   rdata <= {26'h0, ctrl_r};
               OFS_STATUS: rdata <= {31'h0, running};
               OFS_CNT:    rdata <= {16'h0, cnt_r};
               OFS_FIRST_COMPARE_VALUE:  rdata <= {16'h0, first_compare_value_r};
               OFS_SECOND_COMPARE_VALUE:  rdata <= {16'h0, second_compare_value_r};
               OFS_FIRST_REPEAT_COUNT:   rdata <= {24'h0, first_repeat_count_r};
               OFS_SECOND_REPEAT_COUNT:   rdata <= {24'h0, second_repeat_count_r};
               OFS_FLAGS:  rdata <= {27'h0, flags};
               OFS_PRESC:  rdata <= {28'h0, presc_r};
               default:    rdata <= '0;
            endcase
         end
      end
   end

   // Stop beats start in the same write.
   chk_stop_wins: assert property (@(posedge clk) disable iff (!rstSync_r)
      clkEn && cmdStop |=> !running) else $error("stop did not win");
   // Clear forces zero next cycle.
   chk_clear_zero: assert property (@(posedge clk) disable iff (!rstSync_r)
      clkEn && cmdClear |=> cnt_r == '0) else $error("clear did not zero");
   // Underflow raises its flag.
   chk_uf_flag: assert property (@(posedge clk) disable iff (!rstSync_r)
      clkEn && uf && !cmdClear |=> flags[FL_UF]) else $error("underflow flag missing");
   // Underflow reload value.
   chk_top_reload: assert property (@(posedge clk) disable iff (!rstSync_r)
      clkEn && uf && !cmdClear && !bufLoad && !startLoad |=> cnt_r == $past(topVal))
      else $error("bad reload");
   // Write to first repeat wins.
   chk_first_repeat_count_write: assert property (@(posedge clk) disable iff (!rstSync_r)
      clkEn && wrRep0 |=> first_repeat_count_r == $past(busReq.wdata[REP_WIDTH-1:0]))
      else $error("repeat write lost");
   // Write to first compare wins.
   chk_first_compare_value_write: assert property (@(posedge clk) disable iff (!rstSync_r)
      clkEn && wrComp0 |=> first_compare_value_r == $past(busReq.wdata[CNT_WIDTH-1:0]))
      else $error("compare write lost");
   // Free mode never stops by itself.
   chk_free_runs: assert property (@(posedge clk) disable iff (!rstSync_r)
      clkEn && running && mode == MODE_FREE && !cmdStop |=> running)
      else $error("free mode stopped");
   // Consumed marker cleared by a write.
   chk_used_clear: assert property (@(posedge clk) disable iff (!rstSync_r)
      clkEn && wrRep1 |=> !second_repeat_consumed_r) else $error("marker not cleared");
   // The underflow flag holds until cleared.
   chk_flag_sticky: assert property (@(posedge clk) disable iff (!rstSync_r)
      clkEn && !wrClr && flags[FL_UF] |=> flags[FL_UF]) else $error("flag dropped");
   // Tick decrements while running.
   chk_dec_tick: assert property (@(posedge clk) disable iff (!rstSync_r)
      clkEn && running && tick && cnt_r != '0 && !wrCmd |=> cnt_r == $past(cnt_r) - 16'h0001)
      else $error("no decrement");

   // A clear command issued without a start in the same write.
   sequence clearOnly_s;
      clkEn && cmdClear && !startEv;
   endsequence

   // The wrap from zero that follows a clear.
   sequence clearWrap_s;
      clkEn && clrWrap;
   endsequence

   // The underflow that consumes the last one-shot repeat.
   sequence lastShot_s;
      clkEn && (mode == MODE_ONESHOT) && uf && (first_repeat_count_r == 8'h01) && !wrRep0;
   endsequence

   // A clear never produces an underflow in the next cycle.
   chk_clear_no_uf: assert property (@(posedge clk) disable iff (!rstSync_r)
      clearOnly_s |=> !uf) else $error("underflow after clear");

   // A clear leaves both repeat registers and the first compare register alone.
   chk_clear_keeps: assert property (@(posedge clk) disable iff (!rstSync_r)
      clearOnly_s |=> $stable(first_repeat_count_r) && $stable(second_repeat_count_r) && $stable(first_compare_value_r))
      else $error("clear changed registers");

   // The silent wrap after a clear reloads the top value.
   chk_clear_wrap: assert property (@(posedge clk) disable iff (!rstSync_r)
      clearWrap_s |=> cnt_r == $past(topVal)) else $error("bad wrap after clear");

   // One-shot mode stops when the first repeat goes from one to zero.
   chk_oneshot_stop: assert property (@(posedge clk) disable iff (!rstSync_r)
      lastShot_s |=> !running && first_repeat_count_r == '0) else $error("one-shot did not stop");

   // Buffered top copies the second compare into the first.
   chk_buf_top: assert property (@(posedge clk) disable iff (!rstSync_r)
      clkEn && ctrl_r.bufferedTopEnable && decRep0 && first_repeat_count_r == 8'h01 && !wrComp0
      |=> first_compare_value_r == $past(second_compare_value_r)) else $error("buffered top not loaded");

   // First repeat-done flag follows its decrement to zero.
   chk_first_repeat_count_done: assert property (@(posedge clk) disable iff (!rstSync_r)
      clkEn && decRep0 && first_repeat_count_r == 8'h01 && !wrRep0 |=> flags[FL_FIRST_REPEAT_COUNT])
      else $error("first repeat done missing");

   // Second repeat-done flag follows its decrement to zero.
   chk_second_repeat_count_done: assert property (@(posedge clk) disable iff (!rstSync_r)
      clkEn && decRep1 && second_repeat_count_r == 8'h01 && !wrRep1 |=> flags[FL_SECOND_REPEAT_COUNT])
      else $error("second repeat done missing");

   // Double mode keeps running while the second repeat has counts left.
   chk_double_run: assert property (@(posedge clk) disable iff (!rstSync_r)
      clkEn && running && mode == MODE_DOUBLE && uf && second_repeat_count_r > 8'h01 && !cmdStop
      |=> running) else $error("double mode stopped early");

   // An enabled trigger starts a stopped free-running timer.
   chk_trig_start: assert property (@(posedge clk) disable iff (!rstSync_r)
      clkEn && trig && !running && !cmdStop && mode == MODE_FREE |=> running)
      else $error("trigger did not start");

   // A counter match with the first compare raises its flag.
   chk_comp_flag: assert property (@(posedge clk) disable iff (!rstSync_r)
      clkEn && running && tick && cnt_r == first_compare_value_r |=> flags[FL_FIRST_COMPARE_VALUE])
      else $error("compare flag missing");

   // A buffered start from zero loads the second repeat and runs.
   chk_start_load: assert property (@(posedge clk) disable iff (!rstSync_r)
      clkEn && startLoad && !cmdStop |=> running && first_repeat_count_r == $past(second_repeat_count_r))
      else $error("start load missing");

   // A buffered reload takes the unused second repeat and keeps running.
   chk_buf_reload: assert property (@(posedge clk) disable iff (!rstSync_r)
      clkEn && bufLoad && !wrRep0 && !cmdStop |=> running && first_repeat_count_r == $past(second_repeat_count_r))
      else $error("buffered reload missing");

   // The consumed marker is set by a reload and stops a second use.
   chk_used_set: assert property (@(posedge clk) disable iff (!rstSync_r)
      clkEn && bufLoad && !wrRep1 |=> second_repeat_consumed_r) else $error("marker not set");

endmodule

// file: design/down_timer_pkg.sv
package down_timer_pkg;

   localparam int CNT_W = 16;
   localparam int REP_W = 8;
   localparam int ADDR_W = 4;
   localparam int PRESC_W = 4;

   // Register offsets (word indices on the plain port).
   localparam logic [3:0] OFS_CTRL   = 4'h0;
   localparam logic [3:0] OFS_CMD    = 4'h1;
   localparam logic [3:0] OFS_STATUS = 4'h2;
   localparam logic [3:0] OFS_CNT    = 4'h3;
   localparam logic [3:0] OFS_FIRST_COMPARE_VALUE  = 4'h4;
   localparam logic [3:0] OFS_SECOND_COMPARE_VALUE  = 4'h5;
   localparam logic [3:0] OFS_FIRST_REPEAT_COUNT   = 4'h6;
   localparam logic [3:0] OFS_SECOND_REPEAT_COUNT   = 4'h7;
   localparam logic [3:0] OFS_FLAGS  = 4'h8;
   localparam logic [3:0] OFS_FLCLR  = 4'h9;
   localparam logic [3:0] OFS_PRESC  = 4'hA;

   // Control field positions.
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_CTOP     = 2;
   localparam int CTRL_BTOP     = 3;
   localparam int CTRL_TRIG0    = 4;
   localparam int CTRL_TRIG1    = 5;
   // Command bits.
   localparam int CMD_START = 0;
   localparam int CMD_STOP  = 1;
   localparam int CMD_CLEAR = 2;
   // Flag bits.
   localparam int FL_FIRST_COMPARE_VALUE = 0;
   localparam int FL_SECOND_COMPARE_VALUE = 1;
   localparam int FL_UF    = 2;
   localparam int FL_FIRST_REPEAT_COUNT  = 3;
   localparam int FL_SECOND_REPEAT_COUNT  = 4;
   localparam int FL_W     = 5;

   localparam logic [15:0] CNT_WRAP  = 16'hFFFF;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [7:0]  REP_RESET = 8'h00;
   localparam logic [3:0]  PRESC_RESET = 4'h0;

   typedef enum logic [1:0] {
      MODE_FREE, MODE_ONESHOT, MODE_BUFFERED, MODE_DOUBLE
   } repeat_mode_t;

   typedef struct packed {
      logic        rtcChannelOneTriggerEnable;
      logic        rtcChannelZeroTriggerEnable;
      logic        bufferedTopEnable;
      logic        compareAsTopEnable;
      logic [1:0]  repeatModeSelect;
   } ctrl_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0]       wdata;
      logic              wr;
      logic              rd;
   } bus_req_t;

endpackage

// file: tb/rtc_match_model.sv
`timescale 1ns/1ps
// Stand-in for the real-time counter: a request raises one compare match line for a while.
module rtc_match_model #(
   parameter int HOLD = 8
) (
   input  wire logic       clk,       // System clock.
   input  wire logic       reset_n,   // Reset, active low.
   input  wire logic [1:0] fire,      // Match request per channel, one cycle.
   output logic            rtcMatch0, // Channel zero compare match level.
   output logic            rtcMatch1  // Channel one compare match level.
);
   int left0;
   int left1;

   // event spans tick
   // The level lasts HOLD cycles so a timer tick sees it; a shorter event would be missed.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         left0 <= 0;
         left1 <= 0;
      end else begin
         left0 <= fire[0] ? HOLD : (left0 > 0 ? left0 - 1 : 0);
         left1 <= fire[1] ? HOLD : (left1 > 0 ? left1 - 1 : 0);
      end
   end

   assign rtcMatch0 = (left0 != 0);
   assign rtcMatch1 = (left1 != 0);
endmodule

// file: tb/low_energy_down_timer_repeat_tb.sv
`timescale 1ns/1ps
module low_energy_down_timer_repeat_tb;
   import down_timer_pkg::*;
   logic            clk;
   logic            reset_n;
   logic            clkEn;
   logic            lfTick;
   logic [1:0]      fire;
   logic            rtcMatch0;
   logic            rtcMatch1;
   logic            running;
   bus_req_t        busReq;
   logic [31:0]     rdata;
   logic [31:0]     rv;
   logic [31:0]     rv2;
   logic [FL_W-1:0] flags;
   int              fail_count;
   int              num_checks;
   int              n;

   low_energy_down_timer_repeat i_dut (.clk(clk), .reset_n(reset_n), .clkEn(clkEn),
      .lfTick(lfTick), .rtcMatch0(rtcMatch0), .rtcMatch1(rtcMatch1), .busReq(busReq),
      .rdata(rdata), .running(running), .flags(flags));
   rtc_match_model i_rtc (.clk(clk), .reset_n(reset_n), .fire(fire),
      .rtcMatch0(rtcMatch0), .rtcMatch1(rtcMatch1));

   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input string what, input logic [31:0] expV, input logic [31:0] got);
      num_checks++;
      if (got !== expV) begin
         $display("CHECK FAILED %s expected %h seen %h", what, expV, got);
         fail_count++;
      end
   endtask

   task automatic conclude();
      if (fail_count == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // One-cycle strobes launched right after an edge; the slave never stalls.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk) busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk) busReq.wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk) busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk) busReq.rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic tick();
      @(posedge clk) lfTick <= 1'b1;
      @(posedge clk) lfTick <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // Stop and clear, then load control, compares and repeats, and drop all flags.
   task automatic cfg(input logic [31:0] c, input logic [15:0] c0, input logic [15:0] c1,
                      input logic [7:0] r0, input logic [7:0] r1);
      wr(OFS_CMD, 32'h6);
      wr(OFS_CTRL, c);
      wr(OFS_FIRST_COMPARE_VALUE, {16'h0, c0});
      wr(OFS_SECOND_COMPARE_VALUE, {16'h0, c1});
      wr(OFS_FIRST_REPEAT_COUNT, {24'h0, r0});
      wr(OFS_SECOND_REPEAT_COUNT, {24'h0, r1});
      wr(OFS_FLCLR, 32'h1F);
   endtask

   // Counts underflow flags one tick at a time until the timer stops, bounded.
   task automatic count_uf(output int cnt);
      cnt = 0;
      for (int i = 0; i < 80; i++) begin
         tick();
         rd(OFS_FLAGS, rv);
         if (rv[FL_UF] === 1'b1) begin
            cnt++;
            wr(OFS_FLCLR, 32'h4);
         end
         if (running === 1'b0) return;
      end
      chk("run end", 32'h0, {31'h0, running});
      conclude();
   endtask

   initial begin
      reset_n = 1'b0;
      clkEn = 1'b1;
      lfTick = 1'b0;
      fire = 2'b00;
      busReq = '0;
      fail_count = 0;
      num_checks = 0;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd(4'hF, rv);
      chk("unmapped read", 32'h0, rv);
      // Free mode with compare-as-top, then clear with start.
      cfg(32'h4, 16'h5, 16'h3, 8'h0, 8'h0);
      wr(OFS_CMD, 32'h5);
      rd(OFS_CNT, rv);
      chk("cleared counter", 32'h0, rv);
      tick();
      rd(OFS_CNT, rv);
      chk("top after clear", 32'h5, rv);
      rd(OFS_FLAGS, rv);
      chk("no underflow on clear wrap", 32'h0, {31'h0, rv[FL_UF]});
      tick();
      tick();
      rd(OFS_CNT, rv);
      chk("count down", 32'h3, rv);
      repeat (10) tick();
      chk("free keeps running", 32'h1, {31'h0, running});
      chk("compare and underflow flags", 32'h7, {29'h0, flags[2:0]});
      wr(OFS_CMD, 32'h2);
      tick();
      chk("flags stay set", 32'h7, {29'h0, flags[2:0]});
      rd(OFS_CNT, rv);
      wr(OFS_CNT, 32'h1234);
      rd(OFS_CNT, rv2);
      chk("counter not writable", rv, rv2);
      wr(OFS_FLCLR, 32'h1F);
      repeat (2) @(posedge clk);
      chk("flags cleared", 32'h0, {27'h0, flags});
      // Start and stop together.
      wr(OFS_CMD, 32'h1);
      repeat (2) @(posedge clk);
      chk("started", 32'h1, {31'h0, running});
      wr(OFS_CMD, 32'h3);
      repeat (2) @(posedge clk);
      chk("stop wins", 32'h0, {31'h0, running});
      // Prescaler exponent one halves the tick rate; wrap-safe difference.
      cfg(32'h0, 16'h0, 16'h0, 8'h0, 8'h0);
      wr(OFS_PRESC, 32'h1);
      wr(OFS_CMD, 32'h1);
      rd(OFS_CNT, rv);
      repeat (4) tick();
      rd(OFS_CNT, rv2);
      chk("prescaled ticks", 32'h2, {16'h0, rv[15:0] - rv2[15:0]});
      wr(OFS_PRESC, 32'h0);
      // One-shot, buffered top, two underflows.
      cfg(32'hD, 16'h2, 16'h4, 8'h2, 8'h0);
      wr(OFS_CMD, 32'h5);
      count_uf(n);
      chk("one-shot underflows", 32'd2, n);
      rd(OFS_FIRST_COMPARE_VALUE, rv);
      chk("buffered top load", 32'h4, rv);
      chk("first repeat done", 32'h1, {31'h0, flags[FL_FIRST_REPEAT_COUNT]});
      // One-shot extended by a write while running.
      cfg(32'h5, 16'h2, 16'h0, 8'h1, 8'h0);
      wr(OFS_CMD, 32'h5);
      tick();
      wr(OFS_FIRST_REPEAT_COUNT, 32'h3);
      count_uf(n);
      chk("extended run", 32'd3, n);
      // Buffered repeat: second count loaded once when the first finishes.
      cfg(32'h6, 16'h2, 16'h0, 8'h1, 8'h2);
      wr(OFS_CMD, 32'h5);
      count_uf(n);
      chk("buffered underflows", 32'd3, n);
      // Buffered start from zero loads the second repeat count.
      cfg(32'h6, 16'h1, 16'h0, 8'h0, 8'h2);
      wr(OFS_CMD, 32'h5);
      count_uf(n);
      chk("buffered start load", 32'd2, n);
      // Double mode runs for the longer of the two counts.
      cfg(32'h7, 16'h1, 16'h0, 8'h1, 8'h3);
      wr(OFS_CMD, 32'h5);
      count_uf(n);
      chk("double underflows", 32'd3, n);
      chk("both repeats done", 32'h3, {30'h0, flags[FL_SECOND_REPEAT_COUNT], flags[FL_FIRST_REPEAT_COUNT]});
      // Trigger start: channel one disabled, channel zero enabled.
      cfg(32'h10, 16'h0, 16'h0, 8'h0, 8'h0);
      @(posedge clk) fire <= 2'b10;
      @(posedge clk) fire <= 2'b00;
      repeat (3) tick();
      chk("disabled trigger", 32'h0, {31'h0, running});
      @(posedge clk) fire <= 2'b01;
      @(posedge clk) fire <= 2'b00;
      tick();
      chk("trigger start", 32'h1, {31'h0, running});
      conclude();
   end
endmodule
